/* design/lcp_device.sv */
// device end: register bank behind serial and multiplexed host ports
`timescale 1ns/1ps
module lcp_device (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // host link
  lcp_link_if.dev link,
  // strap pins
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_path_mode_pins,
  input wire logic [1:0] i_loopback_sel,
  input wire logic i_shift_edge_select,
  // interrupt events from the line side
  input wire logic [15:0] i_event,
  // configuration towards the line side
  output logic [1:0] o_path_mode,
  output logic [1:0] o_loopback,
  output logic o_inband_en,
  output logic o_sw_ctrl
);

  // ==========================================================
  // pin synchronisers
  localparam int PW = 21;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [5:0] prev;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic ale_s;
  logic rd_s;
  logic wr_s;
  logic [7:0] ad_s;
  logic edge_s;
  lcp_pkg::lcp_mode_t mode;

  assign pin_raw = {link.cs_n, link.sclk, link.serial_in, link.ale_as,
                    link.rd_ds_n, link.wr_rw_n, link.ad, i_mode,
                    i_path_mode_pins, i_loopback_sel, i_shift_edge_select};
  assign cs_n_s = pin_s2[20];
  assign sclk_s = pin_s2[19];
  assign sdi_s = pin_s2[18];
  assign ale_s = pin_s2[17];
  assign rd_s = pin_s2[16];
  assign wr_s = pin_s2[15];
  assign ad_s = pin_s2[14:7];
  assign mode = lcp_pkg::lcp_mode_t'(pin_s2[6:5]);
  assign edge_s = pin_s2[0];

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      pin_s1 <= lcp_pkg::PIN_IDLE;
      pin_s2 <= lcp_pkg::PIN_IDLE;
      prev <= lcp_pkg::PREV_IDLE;
    end
    else if (i_ce)
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      prev <= {cs_n_s, sclk_s, ale_s, rd_s, wr_s, 1'b1};
    end
  end

  // ==========================================================
  // edge events, host side only while selected
  logic sel;
  logic sclk_rise;
  logic sclk_fall;
  logic ale_fall;
  logic rd_fall;
  logic wr_fall;

  assign sel = !cs_n_s;
  assign sclk_rise = sel && (mode == lcp_pkg::CM_SERIAL) && sclk_s &&
                     !prev[4];
  assign sclk_fall = sel && (mode == lcp_pkg::CM_SERIAL) && !sclk_s &&
                     prev[4];
  assign ale_fall = sel && !ale_s && prev[3];
  assign rd_fall = sel && !rd_s && prev[2];
  assign wr_fall = sel && !wr_s && prev[1];

  // ==========================================================
  // register bank
  logic [7:0] global_config;
  logic [7:0] irq_mask_a;
  logic [7:0] irq_mask_b;
  logic [7:0] irq_status_a;
  logic [7:0] irq_status_b;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      lcp_pkg::OFS_GLOBAL_CONFIG: v = global_config;
      lcp_pkg::OFS_IRQ_MASK_A: v = irq_mask_a;
      lcp_pkg::OFS_IRQ_MASK_B: v = irq_mask_b;
      lcp_pkg::OFS_IRQ_STATUS_A: v = irq_status_a;
      lcp_pkg::OFS_IRQ_STATUS_B: v = irq_status_b;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // access decode from whichever port is active
  logic [15:0] sin;
  logic [4:0] bit_cnt;
  logic [7:0] par_addr;
  logic acc_rd;
  logic acc_wr;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] rd_val;

  always_comb
  begin
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_addr = par_addr;
    acc_wdata = ad_s;
    unique case (mode)
      lcp_pkg::CM_SERIAL:
      begin
        if (sclk_rise && bit_cnt == lcp_pkg::SER_CMD_LAST)
        begin
          acc_addr = {1'b0, sin[5:0], sdi_s};
          acc_rd = sin[6];
        end
        else if (sclk_rise && bit_cnt == lcp_pkg::SER_LAST)
        begin
          acc_addr = {1'b0, sin[13:7]};
          acc_wdata = {sin[6:0], sdi_s};
          acc_wr = !sin[14];
        end
      end
      lcp_pkg::CM_ALE:
      begin
        acc_rd = rd_fall;
        acc_wr = wr_fall;
      end
      lcp_pkg::CM_AS:
      begin
        acc_rd = rd_fall && wr_s;
        acc_wr = rd_fall && !wr_s;
      end
      lcp_pkg::CM_HW:
      begin
        acc_rd = 1'b0;
      end
    endcase
  end

  assign rd_val = read_reg(acc_addr);

  // parallel address latch on the falling address strobe
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      par_addr <= 8'h00;
    else if (i_ce && ale_fall && mode != lcp_pkg::CM_SERIAL)
      par_addr <= ad_s;
  end

  // writable registers
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      global_config <= lcp_pkg::RST_REG;
      irq_mask_a <= lcp_pkg::RST_REG;
      irq_mask_b <= lcp_pkg::RST_REG;
    end
    else if (i_ce && acc_wr)
    begin
      if (acc_addr == lcp_pkg::OFS_GLOBAL_CONFIG)
        global_config <= acc_wdata;
      if (acc_addr == lcp_pkg::OFS_IRQ_MASK_A)
        irq_mask_a <= acc_wdata;
      if (acc_addr == lcp_pkg::OFS_IRQ_MASK_B)
        irq_mask_b <= acc_wdata;
    end
  end

  // sticky status, cleared by reading, a new event wins over the clear
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      irq_status_a <= lcp_pkg::RST_REG;
      irq_status_b <= lcp_pkg::RST_REG;
    end
    else if (i_ce)
    begin
      irq_status_a <= (acc_rd && acc_addr == lcp_pkg::OFS_IRQ_STATUS_A ?
                       8'h00 : irq_status_a) | i_event[7:0];
      irq_status_b <= (acc_rd && acc_addr == lcp_pkg::OFS_IRQ_STATUS_B ?
                       8'h00 : irq_status_b) | i_event[15:8];
    end
  end

  // ==========================================================
  // serial shifter
  logic [7:0] sout;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      sin <= 16'h0000;
      bit_cnt <= 5'h00;
      sout <= 8'h00;
      link.serial_out <= 1'b0;
      link.serial_out_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!sel || mode != lcp_pkg::CM_SERIAL)
      begin
        bit_cnt <= 5'h00;
        link.serial_out_oe <= 1'b0;
      end
      else
      begin
        link.serial_out_oe <= 1'b1;
        if (sclk_rise && bit_cnt != lcp_pkg::SER_DONE)
        begin
          sin <= {sin[14:0], sdi_s};
          bit_cnt <= bit_cnt + 5'h01;
        end
        if (acc_rd)
          sout <= rd_val;
        else if ((edge_s ? sclk_fall : sclk_rise) &&
                 bit_cnt >= lcp_pkg::SER_DATA_FIRST &&
                 bit_cnt <= lcp_pkg::SER_LAST)
        begin
          link.serial_out <= sout[7];
          sout <= {sout[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // parallel data drive and ready / acknowledge
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      link.dev_ad <= 8'h00;
      link.dev_ad_oe <= 1'b0;
      link.rdy_ack <= 1'b1;
    end
    else if (i_ce)
    begin
      if (acc_rd)
        link.dev_ad <= rd_val;
      unique case (mode)
        lcp_pkg::CM_ALE:
        begin
          link.dev_ad_oe <= sel && !rd_s;
          link.rdy_ack <= !(acc_rd || acc_wr);
        end
        lcp_pkg::CM_AS:
        begin
          link.dev_ad_oe <= sel && !rd_s && wr_s;
          link.rdy_ack <= !(sel && !rd_s);
        end
        default:
        begin
          link.dev_ad_oe <= 1'b0;
          link.rdy_ack <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // interrupt pin and configuration outputs
  logic irq;

  assign irq = |({irq_status_b, irq_status_a} &
                 ~{irq_mask_b, irq_mask_a});

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      link.int_out <= 1'b0;
      link.int_oe <= 1'b0;
      o_path_mode <= 2'h0;
      o_loopback <= 2'h0;
      o_inband_en <= 1'b0;
      o_sw_ctrl <= 1'b0;
    end
    else if (i_ce)
    begin
      o_sw_ctrl <= mode != lcp_pkg::CM_HW;
      if (mode == lcp_pkg::CM_HW)
      begin
        link.int_out <= 1'b0;
        link.int_oe <= 1'b0;
        o_path_mode <= pin_s2[4:3];
        o_loopback <= pin_s2[2:1];
        o_inband_en <= 1'b0;
      end
      else
      begin
        o_path_mode <= global_config[lcp_pkg::GCF_PATH_LSB +: 2];
        o_loopback <= global_config[lcp_pkg::GCF_LOOP_LSB +: 2];
        o_inband_en <= global_config[lcp_pkg::GCF_INBAND_BIT];
        unique case (global_config[lcp_pkg::GCF_INT_LSB +: 2])
          lcp_pkg::INT_PP_HIGH:
          begin
            link.int_out <= irq;
            link.int_oe <= 1'b1;
          end
          lcp_pkg::INT_PP_LOW:
          begin
            link.int_out <= !irq;
            link.int_oe <= 1'b1;
          end
          default:
          begin
            link.int_out <= 1'b0;
            link.int_oe <= irq;
          end
        endcase
      end
    end
  end

endmodule // lcp_device

/* design/lcp_pkg.sv */
// constants and types shared by both ends of the LIU control host port
package lcp_pkg;

  // ==========================================================
  // control modes, also the host's bus style code
  typedef enum logic [1:0] {CM_HW, CM_SERIAL, CM_ALE, CM_AS} lcp_mode_t;

  // ==========================================================
  // device register offsets and reset values
  localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK_A = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK_B = 8'h15;
  localparam logic [7:0] OFS_IRQ_STATUS_A = 8'h19;
  localparam logic [7:0] OFS_IRQ_STATUS_B = 8'h1a;
  localparam logic [7:0] RST_REG = 8'h00;
  // idle pin levels for the device synchroniser, so reset makes no edge
  localparam logic [20:0] PIN_IDLE = 21'h11_ff80;
  localparam logic [5:0] PREV_IDLE = 6'h27;

  // global_config fields
  localparam int GCF_INT_LSB = 0;
  localparam int GCF_PATH_LSB = 2;
  localparam int GCF_LOOP_LSB = 4;
  localparam int GCF_INBAND_BIT = 6;
  localparam logic [1:0] INT_PP_HIGH = 2'h0;
  localparam logic [1:0] INT_PP_LOW = 2'h1;

  // serial frame: bits counted per select assertion
  localparam logic [4:0] SER_CMD_LAST = 5'h07;
  localparam logic [4:0] SER_DATA_FIRST = 5'h08;
  localparam logic [4:0] SER_LAST = 5'h0f;
  localparam logic [4:0] SER_DONE = 5'h10;

  // ==========================================================
  // host register offsets (byte addresses)
  localparam logic [4:0] HR_CTRL = 5'h00;
  localparam logic [4:0] HR_ADDR = 5'h04;
  localparam logic [4:0] HR_WDATA = 5'h08;
  localparam logic [4:0] HR_RDATA = 5'h0c;
  localparam logic [4:0] HR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] HR_IRQ_MASK = 5'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_STYLE_LSB = 2;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_INT_LOW = 5;
  localparam int HIRQ_DONE = 0;
  localparam int HIRQ_DEV = 1;

  // ==========================================================
  // timing
  localparam int CLK_NS = 100;
  localparam int SCK_HALF_NS = 800;
  localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_NS / CLK_NS);
  localparam logic [3:0] STEP_CYC = 4'h6;

endpackage

/* design/lcp_link_if.sv */
// pins between the LIU control port and its microcontroller
`timescale 1ns/1ps
interface lcp_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic [7:0] host_ad;
  logic host_ad_oe;
  logic [7:0] dev_ad;
  logic dev_ad_oe;
  logic ale_as;
  logic rd_ds_n;
  logic wr_rw_n;
  logic rdy_ack;
  logic int_out;
  logic int_oe;
  // resolved wire levels, pulled high when undriven
  logic serial_out_line;
  logic [7:0] ad;
  logic int_line;

  assign serial_out_line = serial_out_oe ? serial_out : 1'b1;
  assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : 8'hff);
  assign int_line = int_oe ? int_out : 1'b1;

  modport dev (
    input cs_n, sclk, serial_in, ad, ale_as, rd_ds_n, wr_rw_n,
    output serial_out, serial_out_oe, dev_ad, dev_ad_oe, rdy_ack,
    output int_out, int_oe
  );
  modport host (
    output cs_n, sclk, serial_in, host_ad, host_ad_oe, ale_as,
    output rd_ds_n, wr_rw_n,
    input serial_out_line, ad, rdy_ack, int_line
  );
endinterface

/* design/lcp_host.sv */
// host end: AXI4-Lite controlled driver of the LIU control port pins
`timescale 1ns/1ps
module lcp_host (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // AXI4-Lite slave
  input wire logic [4:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [4:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // interrupt
  output logic o_irq,
  // device link
  lcp_link_if.host link
);

  // ==========================================================
  // input synchronisers
  logic [10:0] in_s1;
  logic [10:0] in_s2;
  logic so_s;
  logic rdy_s;
  logic int_s;
  logic int_d;
  logic [7:0] ad_s;

  assign {so_s, rdy_s, int_s, ad_s} = in_s2;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      in_s1 <= 11'h7ff;
      in_s2 <= 11'h7ff;
      int_d <= 1'b1;
    end
    else if (i_ce)
    begin
      in_s1 <= {link.serial_out_line, link.rdy_ack, link.int_line, link.ad};
      in_s2 <= in_s1;
      int_d <= int_s;
    end
  end

  // ==========================================================
  // control registers and AXI4-Lite slave
  logic [5:1] ctrl;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy;
  logic done_ev;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [4:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane;
  logic go;
  logic dev_ev;

  assign go = o_bvalid == 1'b0 && !o_awready && !o_wready && w_lane &&
              aw_addr == lcp_pkg::HR_CTRL && w_data[lcp_pkg::CTRL_GO] && !busy;
  assign dev_ev = (int_s ^ ctrl[lcp_pkg::CTRL_INT_LOW]) &&
                  !(int_d ^ ctrl[lcp_pkg::CTRL_INT_LOW]);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      aw_addr <= 5'h00;
      w_data <= 8'h00;
      w_lane <= 1'b0;
      ctrl <= 5'h00;
      addr <= 8'h00;
      wdata <= 8'h00;
      irq_mask <= 2'h0;
      irq_status <= 2'h0;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_data <= i_wdata[7:0];
        w_lane <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      irq_status <= irq_status | {dev_ev, done_ev};
      if (!o_awready && !o_wready && !o_bvalid)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= 2'h0;
        if (w_lane)
        begin
          unique case (aw_addr)
            lcp_pkg::HR_CTRL: if (!busy) ctrl <= w_data[5:1];
            lcp_pkg::HR_ADDR: addr <= w_data;
            lcp_pkg::HR_WDATA: wdata <= w_data;
            lcp_pkg::HR_IRQ_MASK: irq_mask <= w_data[1:0];
            lcp_pkg::HR_IRQ_STATUS:
              irq_status <= (irq_status & ~w_data[1:0]) | {dev_ev, done_ev};
            lcp_pkg::HR_RDATA: o_bresp <= 2'h0;
            default: o_bresp <= 2'h2;
          endcase
        end
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      o_irq <= |(irq_status & irq_mask);
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= 2'h0;
        unique case (i_araddr)
          lcp_pkg::HR_CTRL: o_rdata <= {26'h0, ctrl, 1'b0};
          lcp_pkg::HR_ADDR: o_rdata <= {24'h0, addr};
          lcp_pkg::HR_WDATA: o_rdata <= {24'h0, wdata};
          lcp_pkg::HR_RDATA: o_rdata <= {23'h0, busy, rdata};
          lcp_pkg::HR_IRQ_STATUS: o_rdata <= {30'h0, irq_status};
          lcp_pkg::HR_IRQ_MASK: o_rdata <= {30'h0, irq_mask};
          default:
          begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'h2;
          end
        endcase
      end
      if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // pin sequencer
  typedef enum logic [2:0] {
    H_IDLE, H_SER, H_ADDR, H_LATCH, H_STROBE, H_WAIT, H_HOLD
  } lcp_hstate_t;
  lcp_hstate_t st;
  logic [3:0] tm;
  logic [4:0] ph;
  logic [15:0] frame;
  logic rd;
  // go delayed one cycle so that ctrl already holds the new style
  logic start;
  lcp_pkg::lcp_mode_t style;

  assign rd = ctrl[lcp_pkg::CTRL_READ];
  assign style = lcp_pkg::lcp_mode_t'(ctrl[lcp_pkg::CTRL_STYLE_LSB +: 2]);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      st <= H_IDLE;
      start <= 1'b0;
      tm <= 4'h0;
      ph <= 5'h00;
      frame <= 16'h0000;
      busy <= 1'b0;
      done_ev <= 1'b0;
      rdata <= 8'h00;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.serial_in <= 1'b0;
      link.host_ad <= 8'h00;
      link.host_ad_oe <= 1'b0;
      link.ale_as <= 1'b0;
      link.rd_ds_n <= 1'b1;
      link.wr_rw_n <= 1'b1;
    end
    else if (i_ce)
    begin
      done_ev <= 1'b0;
      start <= go;
      tm <= tm + 4'h1;
      unique case (st)
        H_IDLE:
        begin
          tm <= 4'h0;
          if (start && style != lcp_pkg::CM_HW)
          begin
            busy <= 1'b1;
            link.cs_n <= 1'b0;
            if (style == lcp_pkg::CM_SERIAL)
            begin
              ph <= 5'h00;
              link.serial_in <= rd;
              frame <= {addr[6:0], wdata, 1'b0};
              st <= H_SER;
            end
            else
            begin
              link.ale_as <= 1'b1;
              link.host_ad <= addr;
              link.host_ad_oe <= 1'b1;
              link.wr_rw_n <= (style == lcp_pkg::CM_AS) ? rd : 1'b1;
              st <= H_ADDR;
            end
          end
        end
        H_SER:
          if (tm == lcp_pkg::SCK_HALF_CYC - 4'h1)
          begin
            tm <= 4'h0;
            ph <= ph + 5'h01;
            link.sclk <= !ph[0];
            if (ph[4] && rd && (ph[0] != ctrl[lcp_pkg::CTRL_EDGE]))
              rdata <= {rdata[6:0], so_s};
            if (ph[0])
            begin
              link.serial_in <= frame[15];
              frame <= {frame[14:0], 1'b0};
            end
            if (ph == 5'h1f)
              st <= H_HOLD;
          end
        H_ADDR:
          if (tm == lcp_pkg::STEP_CYC)
          begin
            tm <= 4'h0;
            link.ale_as <= 1'b0;
            st <= H_LATCH;
          end
        H_LATCH:
          if (tm == lcp_pkg::STEP_CYC)
          begin
            tm <= 4'h0;
            link.host_ad <= wdata;
            link.host_ad_oe <= !rd;
            st <= H_STROBE;
          end
        H_STROBE:
          if (tm == lcp_pkg::STEP_CYC)
          begin
            tm <= 4'h0;
            if (style == lcp_pkg::CM_ALE && !rd)
              link.wr_rw_n <= 1'b0;
            else
              link.rd_ds_n <= 1'b0;
            st <= H_WAIT;
          end
        H_WAIT:
          if (tm >= lcp_pkg::STEP_CYC &&
              rdy_s == (style == lcp_pkg::CM_ALE))
          begin
            tm <= 4'h0;
            if (rd)
              rdata <= ad_s;
            link.rd_ds_n <= 1'b1;
            if (style == lcp_pkg::CM_ALE)
              link.wr_rw_n <= 1'b1;
            st <= H_HOLD;
          end
        H_HOLD:
          if (tm == lcp_pkg::STEP_CYC)
          begin
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.host_ad_oe <= 1'b0;
            link.wr_rw_n <= 1'b1;
            busy <= 1'b0;
            done_ev <= 1'b1;
            st <= H_IDLE;
          end
        default:
          st <= H_IDLE;
      endcase
    end
  end

endmodule // lcp_host

/* sim/lcp_link_asserts.sv */
// link checker for the control port
`timescale 1ns/1ps
module lcp_link_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic dev_ad_oe,
  input wire logic rd_ds_n,
  input wire logic wr_rw_n,
  input wire logic rdy_ack
);
  // ========
  // link rules
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_so_float: assert property (cs_n [*5] |-> !serial_out_oe)
    else $error("so driven idle");
  a_ad_float: assert property (rd_ds_n [*5] |-> !dev_ad_oe)
    else $error("ad driven idle");
  a_ad_read: assert property ($rose(dev_ad_oe) |->
    !rd_ds_n && !cs_n)
    else $error("ad drive cause");
  a_rdy_idle: assert property (cs_n [*5] |-> rdy_ack)
    else $error("rdy low idle");
  a_rdy_cause: assert property ($fell(rdy_ack) |->
    !cs_n && !(rd_ds_n && wr_rw_n))
    else $error("rdy low cause");
  a_so_edge: assert property (serial_out_oe &&
    $past(serial_out_oe) && $changed(serial_out) |->
    $past(sclk, 2) != $past(sclk, 7))
    else $error("so change off edge");
  a_port_excl: assert property (!(serial_out_oe && dev_ad_oe))
    else $error("two ports drive");
  a_sclk_sel: assert property ($rose(sclk) |-> !cs_n)
    else $error("sclk unselected");
  c_serial: cover property ($rose(serial_out_oe));
  c_par_read: cover property ($rose(dev_ad_oe));
  c_ready: cover property ($fell(rdy_ack));
endmodule // lcp_link_asserts

/* sim/tb_top.sv */
// bench driving the host end over axi with the device end attached
`timescale 1ns/1ps
module tb_top;
  logic i_clk;
  logic i_nrst;
  logic [4:0] aw, ar;
  logic [31:0] wd, rd;
  logic awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, irq, edg, ie, sw, ei;
  logic [1:0] rr, br, mode, pth, lps, po, lo;
  logic [15:0] ev;
  logic [7:0] v, ma;
  logic [31:0] seed;
  logic [34:0] q[$];
  int n_fail;
  int check_count;
  lcp_link_if lk();
  lcp_host i_lcp_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_awaddr(aw), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrd), .o_bresp(br),
    .o_bvalid(bv), .i_bready(bry), .i_araddr(ar), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv),
    .i_rready(rry), .o_irq(irq), .link(lk));
  lcp_device i_lcp_device (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .link(lk), .i_mode(mode), .i_path_mode_pins(pth),
    .i_loopback_sel(lps), .i_shift_edge_select(edg), .i_event(ev),
    .o_path_mode(po), .o_loopback(lo), .o_inband_en(ie), .o_sw_ctrl(sw));
  lcp_link_asserts i_lcp_link_asserts (.i_clk(i_clk), .i_nrst(i_nrst),
    .cs_n(lk.cs_n), .sclk(lk.sclk), .serial_out(lk.serial_out),
    .serial_out_oe(lk.serial_out_oe), .dev_ad_oe(lk.dev_ad_oe),
    .rd_ds_n(lk.rd_ds_n), .wr_rw_n(lk.wr_rw_n), .rdy_ack(lk.rdy_ack));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ========
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [34:0] ok8(input logic [7:0] d);
    ok8 = {1'b1, 26'h0, d};
  endfunction
  task automatic chk(input logic [33:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    end_of_test();
  endtask
  task automatic wt(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      n++;
    end while (!bv && n < 99);
    bry <= 1'b0;
    if (!bv) hang();
    chk(34'(br), 34'h0);
  endtask
  task automatic rdt(input logic [4:0] a, input logic [34:0] e);
    int n;
    n = 0;
    q.push_back(e);
    @(posedge i_clk);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (arv && arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 99);
    rry <= 1'b0;
    if (!rv) hang();
  endtask
  // one device access, completion seen through the host interrupt
  task automatic xf(input logic r, input logic [7:0] a, d,
    input logic [34:0] e);
    int n;
    n = 0;
    wt(lcp_pkg::HR_ADDR, 32'(a));
    wt(lcp_pkg::HR_WDATA, 32'(d));
    wt(lcp_pkg::HR_CTRL, 32'({edg, mode, r, 1'b1}));
    while (!irq && n < 3000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (!irq) hang();
    wt(lcp_pkg::HR_IRQ_STATUS, 32'h0000_0001);
    @(posedge i_clk);
    chk(34'(irq), 34'h0);
    if (r) rdt(lcp_pkg::HR_RDATA, e);
  endtask
  always @(posedge i_clk)
  begin
    if (rv && rry && q.size() > 0)
    begin
      if (q[0][34]) chk({rr, rd}, q[0][33:0]);
      void'(q.pop_front());
    end
  end
  // ========
  // main sequence
  initial
  begin
    i_nrst = 1'b0;
    {aw, ar, wd, awv, wv, bry, arv, rry} = '0;
    {mode, pth, lps, edg, ev} = '0;
    seed = 32'h5195_9f0f;
    n_fail = 0;
    check_count = 0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      pth <= 2'(k);
      lps <= ~2'(k);
      repeat (5) @(posedge i_clk);
      chk(34'({sw, ie, lo, po}),
        34'({2'b00, ~2'(k), 2'(k)}));
    end
    wt(lcp_pkg::HR_IRQ_MASK, 32'h0000_0001);
    for (int k = 0; k < 4; k++)
    begin
      mode <= (k == 0) ? 2'h1 : 2'(k);
      edg <= k[0];
      repeat (4) @(posedge i_clk);
      for (int j = 0; j < 2; j++)
      begin
        seed = nx(seed);
        v = seed[7:0] & 8'h7f;
        if (j == 0) ma = v;
        xf(1'b0, j ? lcp_pkg::OFS_GLOBAL_CONFIG : lcp_pkg::OFS_IRQ_MASK_A,
          v, '0);
        xf(1'b1, j ? lcp_pkg::OFS_GLOBAL_CONFIG : lcp_pkg::OFS_IRQ_MASK_A,
          8'h00, ok8(v));
      end
      chk(34'({sw, ie, lo, po}), 34'({1'b1, v[6:2]}));
      seed = nx(seed);
      ev <= seed[15:0];
      @(posedge i_clk);
      ev <= 16'h0000;
      repeat (2) @(posedge i_clk);
      // pin level: request unless masked, inverted for active-low types
      ei = (|seed[15:8] || |(seed[7:0] & ~ma)) ^ (v[1:0] != 2'b00);
      chk(34'(lk.int_line), 34'(ei));
      xf(1'b1, lcp_pkg::OFS_IRQ_STATUS_A, 8'h00, ok8(seed[7:0]));
      xf(1'b1, lcp_pkg::OFS_IRQ_STATUS_B, 8'h00, ok8(seed[15:8]));
    end
    rdt(5'h18, {1'b1, 2'b10, 32'h0000_0000});
    wt(lcp_pkg::HR_IRQ_MASK, 32'h0000_0000);
    wt(lcp_pkg::HR_CTRL, 32'({edg, mode, 2'b01}));
    repeat (600) @(posedge i_clk);
    chk(34'(irq), 34'h0);
    wt(lcp_pkg::HR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk(34'(irq), 34'h1);
    end_of_test();
  end
endmodule // tb_top
